// >>> src/pab_pkg.sv
// pab_pkg: register map, field layout and reset values for the port
// arbitration table (phases 16..31) and power budgeting capability block.
// assumes a 32-bit AXI4-Lite slave with one aligned word per register.
package pab_pkg;
	localparam int          PAB_AW          = 12;
	localparam int          PAB_DW          = 32;
	localparam int          PAB_SLOTS       = 8;
	localparam int          PAB_SLOT_W      = 4;
	localparam int          PAB_NVAL        = 8;
	localparam int          PAB_VIDX_W      = 3;
	localparam logic [11:0] PAB_OFS_TBL2    = 12'h228;
	localparam logic [11:0] PAB_OFS_TBL3    = 12'h22C;
	localparam logic [11:0] PAB_OFS_CAP     = 12'h280;
	localparam logic [11:0] PAB_OFS_DSEL    = 12'h284;
	localparam logic [11:0] PAB_OFS_DWIN    = 12'h288;
	localparam logic [11:0] PAB_OFS_VAL0    = 12'h300;
	localparam logic [11:0] PAB_OFS_VALTOP  = 12'h31C;
	localparam logic [11:0] PAB_OFS_SWITCH_CONTROL_REG   = 12'h404;
	localparam int          PAB_UNLOCK_BIT  = 0;
	localparam logic [31:0] PAB_TBL2_RST    = 32'h3217_6543;
	localparam logic [31:0] PAB_TBL3_RST    = 32'h4321_7654;
	localparam logic [31:0] PAB_CAP_RST     = 32'h0000_0000;
	localparam logic [7:0]  PAB_DSEL_RST    = 8'h00;
	localparam logic [7:0]  PAB_DSEL_MAX    = 8'h07;
	localparam logic [31:0] PAB_ZERO        = 32'h0000_0000;
	localparam logic [3:0]  PAB_PORT_MAX    = 4'h3;
	localparam logic [1:0]  PAB_RESP_OKAY   = 2'b00;
	localparam logic [1:0]  PAB_RESP_SLVERR = 2'b10;
	typedef enum logic [1:0] {
		PAB_W_IDLE = 2'b00,
		PAB_W_RESP = 2'b01
	} pab_wst_e;
	typedef enum logic [1:0] {
		PAB_R_IDLE = 2'b00,
		PAB_R_DATA = 2'b01
	} pab_rst_e;
endpackage

// >>> src/pab_value_mem.sv
// pab_value_mem: eight 32-bit budget data-value words, sticky.
// assumes the same clock; not cleared by reset, read data registered.
`timescale 1ns/1ps
`default_nettype none
module pab_value_mem
	import pab_pkg::*;
(
	input  wire logic                  aclk,   // core clock
	input  wire logic                  wr_en,  // write strobe
	input  wire logic [PAB_VIDX_W-1:0] wr_idx, // word written
	input  wire logic [PAB_DW-1:0]     wr_dat, // write data
	input  wire logic [3:0]            wr_be,  // byte enables
	input  wire logic [PAB_VIDX_W-1:0] rd_idx, // word read
	output logic      [PAB_DW-1:0]     rd_dat  // registered read data
);
	logic [PAB_DW-1:0] mem [PAB_NVAL];
	logic [PAB_DW-1:0] lane_mask;

	// byte mask per lane; one writer keeps the array single-driven
	genvar b;
	generate
		for (b = 0; b < 4; b++) begin : g_lane
			assign lane_mask[8*b +: 8] = {8{wr_be[b]}};
		end
	endgenerate

	// sticky: no reset, survives everything but power
	always_ff @(posedge aclk) begin
		if (wr_en) begin
			mem[wr_idx] <= (mem[wr_idx] & ~lane_mask) | (wr_dat & lane_mask);
		end
	end

	always_ff @(posedge aclk) begin
		rd_dat <= mem[rd_idx];
	end
endmodule
`default_nettype wire

// >>> src/pab_regs.sv
// pab_regs: arbitration phases 16..31 and power budgeting capability
// registers behind an AXI4-Lite slave.
// assumes synchronous active-low reset and one outstanding access per way.
// What this block does
// - Two table words hold eight 4-bit read-write phase fields each, lowest phase in bits 3:0.
// - Phase fields reset to a sequence 3,4,5,6,7,1,2,... wrapping 7 to 1.
// - Cap header bits 15:0 hold the capability id (4 = power budgeting), reset zero.
// - Cap header bits 19:16 version and 31:20 next pointer, both reset zero.
// - Data-select bits 7:0 are read-write, reset zero, pick the value word.
// - Data window returns the value word indexed by the select for 0..7.
// - Data window returns zero when the select is above 7.
// - Phase ids 0..3 name ports; 4..15 are reserved and skipped by the arbiter.
// - Eight sticky value words at 0x300..0x31C are writable only when unlocked.
`timescale 1ns/1ps
`default_nettype none
module pab_regs
	import pab_pkg::*;
(
	input  wire logic              aclk,          // core clock 40 MHz
	input  wire logic              aresetn,       // sync reset, low
	input  wire logic [PAB_AW-1:0] s_axi_awaddr,  // write address
	input  wire logic              s_axi_awvalid, // write addr valid
	output logic                   s_axi_awready, // write addr ready
	input  wire logic [PAB_DW-1:0] s_axi_wdata,   // write data
	input  wire logic [3:0]        s_axi_wstrb,   // byte strobes
	input  wire logic              s_axi_wvalid,  // write data valid
	output logic                   s_axi_wready,  // write data ready
	output logic [1:0]             s_axi_bresp,   // write response
	output logic                   s_axi_bvalid,  // write resp valid
	input  wire logic              s_axi_bready,  // write resp ready
	input  wire logic [PAB_AW-1:0] s_axi_araddr,  // read address
	input  wire logic              s_axi_arvalid, // read addr valid
	output logic                   s_axi_arready, // read addr ready
	output logic [PAB_DW-1:0]      s_axi_rdata,   // read data
	output logic [1:0]             s_axi_rresp,   // read response
	output logic                   s_axi_rvalid,  // read data valid
	input  wire logic              s_axi_rready,  // read data ready
	output logic [PAB_DW-1:0]      port_arb_hi,   // phases 16..23
	output logic [PAB_DW-1:0]      port_arb_top,  // phases 24..31
	output logic [15:0]            slot_valid     // phase names a real port
);
	pab_wst_e          wst_reg, wst_next;
	pab_rst_e          rst_reg, rst_next;
	logic [PAB_AW-1:0] awa_reg, awa_next;
	logic              awh_reg, awh_next;
	logic [PAB_DW-1:0] wd_reg, wd_next;
	logic [3:0]        ws_reg, ws_next;
	logic              wh_reg, wh_next;
	logic [1:0]        br_reg, br_next;
	logic [PAB_AW-1:0] ara_reg, ara_next;
	logic [1:0]        rr_reg, rr_next;
	logic [PAB_DW-1:0] tbl2_reg, tbl2_next;
	logic [PAB_DW-1:0] tbl3_reg, tbl3_next;
	logic [PAB_DW-1:0] cap_reg, cap_next;
	logic [7:0]        dsel_reg, dsel_next;
	logic [PAB_DW-1:0] switch_control_reg_reg, switch_control_reg_next;
	logic [PAB_DW-1:0] rdat_reg, rdat_next;
	logic              do_wr;
	logic              hit_val;
	logic              unlocked;
	logic              mem_we;
	logic [PAB_DW-1:0] mem_q;
	logic [PAB_DW-1:0] bm;
	logic              rmem_reg, rmem_next;

	assign s_axi_awready = (wst_reg == PAB_W_IDLE) && !awh_reg;
	assign s_axi_wready  = (wst_reg == PAB_W_IDLE) && !wh_reg;
	assign s_axi_bvalid  = (wst_reg == PAB_W_RESP);
	assign s_axi_bresp   = br_reg;
	assign s_axi_arready = (rst_reg == PAB_R_IDLE);
	// memory reads hold rvalid back one cycle so rdata stays a flop
	assign s_axi_rvalid  = (rst_reg == PAB_R_DATA) && !rmem_reg;
	assign s_axi_rresp   = rr_reg;
	assign s_axi_rdata   = rdat_reg;
	assign port_arb_hi   = tbl2_reg;
	assign port_arb_top  = tbl3_reg;
	assign do_wr    = (wst_reg == PAB_W_IDLE) && awh_reg && wh_reg;
	assign hit_val  = (awa_reg >= PAB_OFS_VAL0) && (awa_reg <= PAB_OFS_VALTOP)
		&& (awa_reg[1:0] == 2'h0);
	assign unlocked = switch_control_reg_reg[PAB_UNLOCK_BIT];
	assign mem_we   = do_wr && hit_val && unlocked;

	// flag ports 0..3 valid, 4..15 skipped
	genvar g;
	generate
		for (g = 0; g < 16; g++) begin : g_slot
			if (g < 8) begin : g_lo
				assign slot_valid[g] = tbl2_reg[4*g +: 4] <= PAB_PORT_MAX;
			end else begin : g_hi
				assign slot_valid[g] = tbl3_reg[4*(g-8) +: 4] <= PAB_PORT_MAX;
			end
		end
	endgenerate

	always_comb begin
		for (int i = 0; i < 4; i++) begin
			bm[8*i +: 8] = wd_reg[8*i +: 8] & {8{ws_reg[i]}};
		end
	end

	// write channel and register updates
	always_comb begin
		wst_next   = wst_reg;
		awa_next   = awa_reg;
		awh_next   = awh_reg;
		wd_next    = wd_reg;
		ws_next    = ws_reg;
		wh_next    = wh_reg;
		br_next    = br_reg;
		tbl2_next  = tbl2_reg;
		tbl3_next  = tbl3_reg;
		cap_next   = cap_reg;
		dsel_next  = dsel_reg;
		switch_control_reg_next = switch_control_reg_reg;
		if (s_axi_awvalid && s_axi_awready) begin
			awa_next = s_axi_awaddr;
			awh_next = 1'b1;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			wd_next = s_axi_wdata;
			ws_next = s_axi_wstrb;
			wh_next = 1'b1;
		end
		case (wst_reg)
			PAB_W_IDLE: begin
				if (do_wr) begin
					awh_next = 1'b0;
					wh_next  = 1'b0;
					wst_next = PAB_W_RESP;
					br_next  = PAB_RESP_OKAY;
					case (awa_reg)
						PAB_OFS_TBL2: tbl2_next = (tbl2_reg & ~mask(ws_reg)) | bm;
						PAB_OFS_TBL3: tbl3_next = (tbl3_reg & ~mask(ws_reg)) | bm;
						// header loaded only by software writes
						PAB_OFS_CAP:  cap_next = (cap_reg & ~mask(ws_reg)) | bm;
						PAB_OFS_DSEL: if (ws_reg[0]) dsel_next = wd_reg[7:0];
						PAB_OFS_DWIN: br_next = PAB_RESP_OKAY;
						PAB_OFS_SWITCH_CONTROL_REG: if (ws_reg[0]) begin
							switch_control_reg_next[PAB_UNLOCK_BIT] = wd_reg[PAB_UNLOCK_BIT];
						end
						default: if (!hit_val) br_next = PAB_RESP_SLVERR;
					endcase
				end
			end
			PAB_W_RESP: begin
				if (s_axi_bready) begin
					wst_next = PAB_W_IDLE;
				end
			end
			default: wst_next = PAB_W_IDLE;
		endcase
	end

	function automatic logic [31:0] mask(input logic [3:0] s);
		logic [31:0] m;
		for (int i = 0; i < 4; i++) begin
			m[8*i +: 8] = {8{s[i]}};
		end
		return m;
	endfunction

	// read channel; value word fetched the cycle after arready
	always_comb begin
		rst_next  = rst_reg;
		ara_next  = ara_reg;
		rr_next   = rr_reg;
		// freeze memory data once they land
		rdat_next = rmem_reg ? mem_q : rdat_reg;
		case (rst_reg)
			PAB_R_IDLE: begin
				if (s_axi_arvalid) begin
					ara_next = s_axi_araddr;
					rst_next = PAB_R_DATA;
					rr_next  = PAB_RESP_OKAY;
					case (s_axi_araddr)
						PAB_OFS_TBL2:  rdat_next = tbl2_reg;
						PAB_OFS_TBL3:  rdat_next = tbl3_reg;
						PAB_OFS_CAP:   rdat_next = cap_reg;
						PAB_OFS_DSEL:  rdat_next = {24'h00_0000, dsel_reg};
						// window via memory, zero above 7
						PAB_OFS_DWIN:  rdat_next = PAB_ZERO;
						PAB_OFS_SWITCH_CONTROL_REG: rdat_next = switch_control_reg_reg;
						default: begin
							rdat_next = PAB_ZERO;
							if (!(s_axi_araddr >= PAB_OFS_VAL0
								&& s_axi_araddr <= PAB_OFS_VALTOP
								&& s_axi_araddr[1:0] == 2'h0)) begin
								rr_next = PAB_RESP_SLVERR;
							end
						end
					endcase
				end
			end
			PAB_R_DATA: begin
				if (s_axi_rvalid && s_axi_rready) begin
					rst_next = PAB_R_IDLE;
				end
			end
			default: rst_next = PAB_R_IDLE;
		endcase
	end

	logic [PAB_VIDX_W-1:0] ridx;

	// window reads index by select; direct reads index by address
	always_comb begin
		rmem_next = 1'b0;
		ridx = dsel_reg[PAB_VIDX_W-1:0];
		if (rst_reg == PAB_R_IDLE && s_axi_arvalid) begin
			if (s_axi_araddr == PAB_OFS_DWIN) begin
				rmem_next = (dsel_reg <= PAB_DSEL_MAX);
			end else if (s_axi_araddr >= PAB_OFS_VAL0
				&& s_axi_araddr <= PAB_OFS_VALTOP
				&& s_axi_araddr[1:0] == 2'h0) begin
				rmem_next = 1'b1;
				ridx = s_axi_araddr[2 +: PAB_VIDX_W];
			end
		end
	end

	pab_value_mem u_mem (
		.aclk   (aclk),
		.wr_en  (mem_we),
		.wr_idx (awa_reg[2 +: PAB_VIDX_W]),
		.wr_dat (wd_reg),
		.wr_be  (ws_reg),
		.rd_idx (ridx),
		.rd_dat (mem_q)
	);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wst_reg   <= PAB_W_IDLE;
			rst_reg   <= PAB_R_IDLE;
			awa_reg   <= '0;
			awh_reg   <= 1'b0;
			wd_reg    <= PAB_ZERO;
			ws_reg    <= 4'h0;
			wh_reg    <= 1'b0;
			br_reg    <= PAB_RESP_OKAY;
			ara_reg   <= '0;
			rr_reg    <= PAB_RESP_OKAY;
			tbl2_reg  <= PAB_TBL2_RST;
			tbl3_reg  <= PAB_TBL3_RST;
			cap_reg   <= PAB_CAP_RST;
			dsel_reg  <= PAB_DSEL_RST;
			switch_control_reg_reg <= PAB_ZERO;
			rdat_reg  <= PAB_ZERO;
			rmem_reg  <= 1'b0;
		end else begin
			wst_reg   <= wst_next;
			rst_reg   <= rst_next;
			awa_reg   <= awa_next;
			awh_reg   <= awh_next;
			wd_reg    <= wd_next;
			ws_reg    <= ws_next;
			wh_reg    <= wh_next;
			br_reg    <= br_next;
			ara_reg   <= ara_next;
			rr_reg    <= rr_next;
			tbl2_reg  <= tbl2_next;
			tbl3_reg  <= tbl3_next;
			cap_reg   <= cap_next;
			dsel_reg  <= dsel_next;
			switch_control_reg_reg <= switch_control_reg_next;
			rdat_reg  <= rdat_next;
			rmem_reg  <= rmem_next;
		end
	end

	AST_PHASE_RESET: assert property (@(posedge aclk)
		!aresetn |=> tbl2_reg == 32'h3217_6543 && tbl3_reg == 32'h4321_7654)
		else $error("phase reset pattern wrong");
	AST_TBL_WRITE: assert property (@(posedge aclk) disable iff (!aresetn)
		do_wr && awa_reg == PAB_OFS_TBL2 && ws_reg == 4'hF |=> tbl2_reg == $past(wd_reg))
		else $error("table write lost");
	AST_CAP_WRITE: assert property (@(posedge aclk) disable iff (!aresetn)
		do_wr && awa_reg == PAB_OFS_CAP && ws_reg == 4'hF |=> cap_reg == $past(wd_reg))
		else $error("header write lost");
	AST_CAP_RESET: assert property (@(posedge aclk)
		!aresetn |=> cap_reg == 32'h0000_0000)
		else $error("header not cleared");
	AST_DSEL_WRITE: assert property (@(posedge aclk) disable iff (!aresetn)
		do_wr && awa_reg == PAB_OFS_DSEL && ws_reg[0] |=> dsel_reg == $past(wd_reg[7:0]))
		else $error("select write lost");
	AST_WIN_ZERO: assert property (@(posedge aclk) disable iff (!aresetn)
		rst_reg == PAB_R_IDLE && s_axi_arvalid && s_axi_araddr == PAB_OFS_DWIN
		&& dsel_reg > 8'h07 |=> s_axi_rvalid && s_axi_rdata == 32'h0000_0000)
		else $error("window not zero");
	AST_WIN_SEL: assert property (@(posedge aclk) disable iff (!aresetn)
		rst_reg == PAB_R_IDLE && s_axi_arvalid && s_axi_araddr == PAB_OFS_DWIN
		&& dsel_reg <= 8'h07 |=> rmem_reg)
		else $error("window not from value word");
	AST_LOCKED: assert property (@(posedge aclk) disable iff (!aresetn)
		do_wr && hit_val && !switch_control_reg_reg[0]
		|=> u_mem.mem[awa_reg[2 +: PAB_VIDX_W]]
			== $past(u_mem.mem[awa_reg[2 +: PAB_VIDX_W]]))
		else $error("value word written while locked");
	AST_DSEL_HI: assert property (@(posedge aclk) disable iff (!aresetn)
		s_axi_rvalid && ara_reg == PAB_OFS_DSEL |-> s_axi_rdata[31:8] == 24'h0)
		else $error("select upper bits nonzero");
endmodule
`default_nettype wire

// >>> verif/tb_port_arb_table_power_budget_regs.sv
// tb_port_arb_table_power_budget_regs: directed AXI4-Lite register tests.
// assumes the design checks its own assertions; value words power up undefined.
`timescale 1ns/1ps
`default_nettype none
module tb_port_arb_table_power_budget_regs
	import pab_pkg::*;
;
	logic              aclk;
	logic              aresetn;
	logic [PAB_AW-1:0] s_axi_awaddr;
	logic [PAB_AW-1:0] s_axi_araddr;
	logic [PAB_DW-1:0] s_axi_wdata;
	logic [PAB_DW-1:0] s_axi_rdata;
	logic [3:0]        s_axi_wstrb;
	logic [1:0]        s_axi_bresp;
	logic [1:0]        s_axi_rresp;
	logic              s_axi_awvalid, s_axi_awready, s_axi_wvalid;
	logic              s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic              s_axi_arvalid, s_axi_arready, s_axi_rvalid;
	logic              s_axi_rready;
	logic [PAB_DW-1:0] port_arb_hi;
	logic [PAB_DW-1:0] port_arb_top;
	logic [15:0]       slot_valid;
	int                n_errors = 0;
	int                comparisons = 0;
	int                cycles = 0;
	logic [31:0]       rd;
	logic [31:0]       t2;
	logic [31:0]       t3;
	logic [31:0]       vw [8];
	logic [7:0]        sel;
	logic [1:0]        rsp;

	pab_regs u_pab_regs (
		.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready), .port_arb_hi(port_arb_hi),
		.port_arb_top(port_arb_top), .slot_valid(slot_valid)
	);

	initial begin
		aclk = 1'b0;
		forever #12.5 aclk = ~aclk;
	end

	task automatic final_report;
		$display("comparisons=%0d mismatches=%0d", comparisons, n_errors);
		if (n_errors == 0 && comparisons > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// whole run needs well under a thousand cycles
	always @(posedge aclk) begin
		cycles++;
		if (cycles == 5000) begin
			n_errors++;
			$display("MISMATCH t=%0t timeout got=%h exp=%h", $time, 1'b0, 1'b1);
			final_report;
		end
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			n_errors++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// port id 0..3 is a real port, anything higher is skipped
	function automatic logic [31:0] vmask(input logic [31:0] lo, hi);
		logic [31:0] m;
		m = 32'h0;
		for (int i = 0; i < 8; i++) begin
			m[i] = lo[4*i +: 4] <= 4'h3;
			m[8+i] = hi[4*i +: 4] <= 4'h3;
		end
		return m;
	endfunction

	// first edge only launches; aw and w may be taken at different edges
	task automatic wr(input logic [11:0] a, input logic [31:0] d,
			input logic [3:0] s);
		bit aw_ok;
		bit w_ok;
		bit b_ok;
		aw_ok = 0;
		w_ok = 0;
		b_ok = 0;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_wstrb <= s;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (!b_ok) begin
			@(posedge aclk);
			if (!aw_ok && s_axi_awready) begin
				aw_ok = 1;
				s_axi_awvalid <= 1'b0;
			end
			if (!w_ok && s_axi_wready) begin
				w_ok = 1;
				s_axi_wvalid <= 1'b0;
			end
			if (s_axi_bvalid) begin
				b_ok = 1;
				rsp = s_axi_bresp;
				s_axi_bready <= 1'b0;
			end
		end
	endtask

	task automatic rdr(input logic [11:0] a);
		bit ar_ok;
		bit r_ok;
		ar_ok = 0;
		r_ok = 0;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		while (!r_ok) begin
			@(posedge aclk);
			if (!ar_ok && s_axi_arready) begin
				ar_ok = 1;
				s_axi_arvalid <= 1'b0;
			end
			if (s_axi_rvalid) begin
				r_ok = 1;
				rd = s_axi_rdata;
				rsp = s_axi_rresp;
				s_axi_rready <= 1'b0;
			end
		end
	endtask

	initial begin
		aresetn = 1'b0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'b000;
		{s_axi_arvalid, s_axi_rready} = 2'b00;
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		// expected table defaults rotate 1..7 from 3, written out here
		rdr(PAB_OFS_TBL2); chk(rd, 32'h3217_6543);
		rdr(PAB_OFS_TBL3); chk(rd, 32'h4321_7654);
		chk(port_arb_top, 32'h4321_7654);
		chk({16'h0, slot_valid}, vmask(32'h3217_6543, 32'h4321_7654));
		rdr(PAB_OFS_CAP); chk(rd, 32'h0000_0000);
		rdr(PAB_OFS_DSEL); chk(rd, 32'h0000_0000);
		$display("test reset_values done");

		t2 = 32'h0123_3210;
		t3 = 32'h4321_7655;
		wr(PAB_OFS_TBL2, t2, 4'hF); rdr(PAB_OFS_TBL2); chk(rd, t2);
		wr(PAB_OFS_TBL3, 32'h9999_9955, 4'h1); rdr(PAB_OFS_TBL3); chk(rd, t3);
		chk(port_arb_hi, t2);
		chk(port_arb_top, t3);
		chk({16'h0, slot_valid}, vmask(t2, t3));
		$display("test arb_table done");

		wr(PAB_OFS_CAP, 32'hABC1_0004, 4'hF); rdr(PAB_OFS_CAP); chk(rd, 32'hABC1_0004);
		$display("test cap_header done");

		wr(PAB_OFS_SWITCH_CONTROL_REG, 32'h0000_0001, 4'hF);
		for (int i = 0; i < 8; i++) begin
			vw[i] = 32'h5A00_0000 | (32'h0001_0101 * i);
			wr(PAB_OFS_VAL0 + 12'(4 * i), vw[i], 4'hF);
		end
		// locked again: this write must be dropped
		wr(PAB_OFS_SWITCH_CONTROL_REG, 32'h0000_0000, 4'hF);
		wr(PAB_OFS_VAL0 + 12'h008, 32'hDEAD_BEEF, 4'hF);
		for (int i = 0; i < 8; i++) begin
			rdr(PAB_OFS_VAL0 + 12'(4 * i)); chk(rd, vw[i]);
		end
		$display("test value_words done");

		for (int k = 0; k < 10; k++) begin
			sel = (k < 8) ? 8'(k) : ((k == 8) ? 8'h08 : 8'hFF);
			wr(PAB_OFS_DSEL, {24'hFFFFFF, sel}, 4'hF);
			rdr(PAB_OFS_DSEL); chk(rd, {24'h0, sel});
			rdr(PAB_OFS_DWIN); chk(rd, (k < 8) ? vw[k] : 32'h0);
		end
		wr(PAB_OFS_DSEL, 32'h0000_0003, 4'hF);
		wr(PAB_OFS_DWIN, 32'h1234_5678, 4'hF);
		rdr(PAB_OFS_DWIN); chk(rd, vw[3]);
		$display("test data_window done");

		// mid-run reset: tables reload defaults and select clears, value words are sticky
		aresetn <= 1'b0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		rdr(PAB_OFS_TBL2); chk(rd, 32'h3217_6543);
		rdr(PAB_OFS_DSEL); chk(rd, 32'h0000_0000);
		rdr(PAB_OFS_VAL0 + 12'h014); chk(rd, vw[5]);
		$display("test sticky_reset done");

		rdr(12'h100); chk(rd, 32'h0000_0000);
		chk({30'h0, rsp}, {30'h0, PAB_RESP_SLVERR});
		wr(12'h100, 32'hFFFF_FFFF, 4'hF); chk({30'h0, rsp}, {30'h0, PAB_RESP_SLVERR});
		$display("test unmapped done");
		final_report;
	end
endmodule
`default_nettype wire
